/* opd_params.svh */
`ifndef OPD_PARAMS_SVH
`define OPD_PARAMS_SVH

// addressing byte layout
`define OPD_MOD_MSB 7
`define OPD_MOD_LSB 6
`define OPD_REG_MSB 5
`define OPD_REG_LSB 3
`define OPD_RM_MSB 2
`define OPD_RM_LSB 0

// scale-index-base byte layout
`define OPD_SS_MSB 7
`define OPD_SS_LSB 6
`define OPD_IDX_MSB 5
`define OPD_IDX_LSB 3
`define OPD_BASE_MSB 2
`define OPD_BASE_LSB 0

// mode subfield codes
`define OPD_MOD_NODISP 2'h0
`define OPD_MOD_DISP8 2'h1
`define OPD_MOD_DISPW 2'h2
`define OPD_MOD_REG 2'h3

// special r/m, base and index codes
`define OPD_RM_SIB 3'h4
`define OPD_RM16_DIRECT 3'h6
`define OPD_BASE32_DIRECT 3'h5
`define OPD_BASE32_STACK 3'h4
`define OPD_IDX_NONE 3'h4

// first reserved three-bit segment code
`define OPD_SEG3_RSVD_MIN 3'h6

// reset values
`define OPD_RST_BIT 1'b0
`define OPD_RST_CODE3 3'h0
`define OPD_RST_SCALE 2'h0

// decode latency in clock cycles
`define OPD_LATENCY 1

`endif

/* opd_pkg.sv */
package opd_pkg;

	// general registers, byte, word and extended sets
	typedef enum logic [4:0] {
		gpr_none,
		gpr_al, gpr_cl, gpr_dl, gpr_bl, gpr_ah, gpr_ch, gpr_dh, gpr_bh,
		gpr_ax, gpr_cx, gpr_dx, gpr_bx, gpr_sp, gpr_bp, gpr_si, gpr_di,
		gpr_eax, gpr_ecx, gpr_edx, gpr_ebx, gpr_esp, gpr_ebp, gpr_esi, gpr_edi
	} opd_gpr_t;

	typedef enum logic [2:0] {
		seg_none,
		seg_es,
		seg_cs,
		seg_ss,
		seg_ds,
		seg_fs,
		seg_gs
	} opd_seg_t;

	typedef enum logic [1:0] {
		disp_none,
		disp8,
		disp16,
		disp32
	} opd_disp_t;

	typedef enum logic [1:0] {
		size_8,
		size_16,
		size_32
	} opd_size_t;

endpackage : opd_pkg

/* opd_reg_map.sv */
`timescale 1ns/1ns

// maps one three-bit register code onto a general register
module opd_reg_map #(
	parameter int CODE_W = 3
) (
	// code and size qualifiers
	input wire logic [CODE_W-1:0] code_i,
	input wire logic width_present_i,
	input wire logic width_bit_i,
	input wire logic op32_i,
	// selected register
	output opd_pkg::opd_gpr_t gpr_o
);

	if (CODE_W != 3) begin : g_bad_width
		$error("opd_reg_map serves three-bit codes only");
	end

	opd_pkg::opd_gpr_t byte_reg;
	opd_pkg::opd_gpr_t word_reg;
	opd_pkg::opd_gpr_t ext_reg;

	always_comb begin
		unique case (code_i)
			3'h0: begin byte_reg = opd_pkg::gpr_al; word_reg = opd_pkg::gpr_ax; ext_reg = opd_pkg::gpr_eax; end
			3'h1: begin byte_reg = opd_pkg::gpr_cl; word_reg = opd_pkg::gpr_cx; ext_reg = opd_pkg::gpr_ecx; end
			3'h2: begin byte_reg = opd_pkg::gpr_dl; word_reg = opd_pkg::gpr_dx; ext_reg = opd_pkg::gpr_edx; end
			3'h3: begin byte_reg = opd_pkg::gpr_bl; word_reg = opd_pkg::gpr_bx; ext_reg = opd_pkg::gpr_ebx; end
			3'h4: begin byte_reg = opd_pkg::gpr_ah; word_reg = opd_pkg::gpr_sp; ext_reg = opd_pkg::gpr_esp; end
			3'h5: begin byte_reg = opd_pkg::gpr_ch; word_reg = opd_pkg::gpr_bp; ext_reg = opd_pkg::gpr_ebp; end
			3'h6: begin byte_reg = opd_pkg::gpr_dh; word_reg = opd_pkg::gpr_si; ext_reg = opd_pkg::gpr_esi; end
			3'h7: begin byte_reg = opd_pkg::gpr_bh; word_reg = opd_pkg::gpr_di; ext_reg = opd_pkg::gpr_edi; end
		endcase
	end

	always_comb begin
		if (width_present_i && !width_bit_i) begin
			gpr_o = byte_reg;
		end else if (op32_i) begin
			gpr_o = ext_reg;
		end else begin
			gpr_o = word_reg;
		end
	end

endmodule : opd_reg_map

/* opd_decoder.sv */
`timescale 1ns/1ns
`include "opd_params.svh"

// Overview of operation
// - width bit zero selects byte registers
// - width one, 16-bit: word registers in order
// - width one, 32-bit: extended registers, same order
// - two-bit segment code maps ES CS SS DS
// - three-bit code adds FS GS; 110/111 reserved
// - push/pop use predetermined stack addressing
// - 32-bit, r/m 100, mod not 11: sib follows
// - sib fields plus mod form 32-bit mode
// - middle bits may extend the opcode
// - otherwise middle bits select general register
// - address size picks 16- or 32-bit interpretation
// - 16-bit mod 00 base/index table, segments
// - mod 01 disp8, mod 10 disp16; 110 is BP
// - mod 11 selects register operand from r/m
// - width bit picks byte or full size
// - sizes from code default bit, prefixes toggle
module opd_decoder #(
	parameter int REG_CODE_W = 3
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// instruction fields from the front end
	input wire logic req_valid_i,
	input wire logic has_modrm_i,
	input wire logic [7:0] modrm_i,
	input wire logic [7:0] sib_i,
	input wire logic width_present_i,
	input wire logic width_bit_i,
	input wire logic opcode_ext_sel_i,
	input wire logic fixed_stack_mode_i,
	input wire logic [1:0] segment_select_2b_i,
	input wire logic [2:0] segment_select_3b_i,
	input wire logic seg3_used_i,
	// size context
	input wire logic cs_default_size_i,
	input wire logic real_or_v86_i,
	input wire logic opsize_prefix_i,
	input wire logic addrsize_prefix_i,
	// decode result, valid one cycle after the request
	output logic out_valid_o,
	output logic op32_o,
	output logic addr32_o,
	output opd_pkg::opd_size_t operand_size_o,
	output logic reg_valid_o,
	output opd_pkg::opd_gpr_t reg_sel_o,
	output logic ext_valid_o,
	output logic [2:0] opcode_extension_bits_o,
	output logic rm_is_reg_o,
	output opd_pkg::opd_gpr_t rm_reg_o,
	output logic mem_valid_o,
	output logic sib_needed_o,
	output logic base_valid_o,
	output opd_pkg::opd_gpr_t base_o,
	output logic index_valid_o,
	output opd_pkg::opd_gpr_t index_o,
	output logic [1:0] scale_o,
	output opd_pkg::opd_disp_t disp_size_o,
	output opd_pkg::opd_seg_t ea_seg_o,
	output logic fixed_mode_o,
	output opd_pkg::opd_seg_t segment_select_2b_o,
	output opd_pkg::opd_seg_t segment_select_3b_o,
	output logic seg3_valid_o,
	output logic invalid_opcode_o
);

	if (REG_CODE_W != 3) begin : g_bad_width
		$error("opd_decoder serves three-bit register codes only");
	end

	logic [1:0] mod_f;
	logic [2:0] reg_f;
	logic [2:0] rm_f;
	logic [1:0] ss_f;
	logic [2:0] idx_f;
	logic [2:0] base_f;
	logic d_eff;
	logic op32_next;
	logic addr32_next;
	opd_pkg::opd_size_t size_next;
	opd_pkg::opd_gpr_t reg_map;
	opd_pkg::opd_gpr_t rm_map;
	opd_pkg::opd_gpr_t rm_ext;
	opd_pkg::opd_gpr_t sib_base_ext;
	opd_pkg::opd_gpr_t sib_idx_ext;

	assign mod_f = modrm_i[`OPD_MOD_MSB:`OPD_MOD_LSB];
	assign reg_f = modrm_i[`OPD_REG_MSB:`OPD_REG_LSB];
	assign rm_f = modrm_i[`OPD_RM_MSB:`OPD_RM_LSB];
	assign ss_f = sib_i[`OPD_SS_MSB:`OPD_SS_LSB];
	assign idx_f = sib_i[`OPD_IDX_MSB:`OPD_IDX_LSB];
	assign base_f = sib_i[`OPD_BASE_MSB:`OPD_BASE_LSB];

	// real and virtual-8086 modes see no descriptor, so the default is 16-bit
	assign d_eff = cs_default_size_i & ~real_or_v86_i;
	assign op32_next = d_eff ^ opsize_prefix_i;
	assign addr32_next = d_eff ^ addrsize_prefix_i;

	always_comb begin
		if (width_present_i && !width_bit_i) begin
			size_next = opd_pkg::size_8;
		end else if (op32_next) begin
			size_next = opd_pkg::size_32;
		end else begin
			size_next = opd_pkg::size_16;
		end
	end

	// middle field and r/m share the same register mapping
	opd_reg_map #(.CODE_W(REG_CODE_W)) u_map_reg (
		.code_i(reg_f),
		.width_present_i(width_present_i),
		.width_bit_i(width_bit_i),
		.op32_i(op32_next),
		.gpr_o(reg_map)
	);

	opd_reg_map #(.CODE_W(REG_CODE_W)) u_map_rm (
		.code_i(rm_f),
		.width_present_i(width_present_i),
		.width_bit_i(width_bit_i),
		.op32_i(op32_next),
		.gpr_o(rm_map)
	);

	// 32-bit address components are always full 32-bit registers
	opd_reg_map #(.CODE_W(REG_CODE_W)) u_map_rm_ext (
		.code_i(rm_f),
		.width_present_i(1'b0),
		.width_bit_i(1'b1),
		.op32_i(1'b1),
		.gpr_o(rm_ext)
	);

	opd_reg_map #(.CODE_W(REG_CODE_W)) u_map_sib_base (
		.code_i(base_f),
		.width_present_i(1'b0),
		.width_bit_i(1'b1),
		.op32_i(1'b1),
		.gpr_o(sib_base_ext)
	);

	opd_reg_map #(.CODE_W(REG_CODE_W)) u_map_sib_idx (
		.code_i(idx_f),
		.width_present_i(1'b0),
		.width_bit_i(1'b1),
		.op32_i(1'b1),
		.gpr_o(sib_idx_ext)
	);

	// effective address decode
	logic mem_next;
	logic sib_next;
	logic base_v_next;
	logic idx_v_next;
	opd_pkg::opd_gpr_t base_next;
	opd_pkg::opd_gpr_t idx_next;
	logic [1:0] scale_next;
	opd_pkg::opd_disp_t disp_next;
	opd_pkg::opd_seg_t seg_next;

	always_comb begin
		mem_next = 1'b0;
		sib_next = 1'b0;
		base_v_next = 1'b0;
		idx_v_next = 1'b0;
		base_next = opd_pkg::gpr_none;
		idx_next = opd_pkg::gpr_none;
		scale_next = `OPD_RST_SCALE;
		disp_next = opd_pkg::disp_none;
		seg_next = opd_pkg::seg_none;
		if (fixed_stack_mode_i) begin
			// stack operations ignore any addressing byte
			mem_next = 1'b1;
			base_v_next = 1'b1;
			base_next = addr32_next ? opd_pkg::gpr_esp : opd_pkg::gpr_sp;
			seg_next = opd_pkg::seg_ss;
		end else if (has_modrm_i && mod_f != `OPD_MOD_REG) begin
			mem_next = 1'b1;
			if (!addr32_next) begin
				// 16-bit interpretation with 16-bit components
				base_v_next = 1'b1;
				seg_next = opd_pkg::seg_ds;
				unique case (rm_f)
					3'h0: begin base_next = opd_pkg::gpr_bx; idx_next = opd_pkg::gpr_si; end
					3'h1: begin base_next = opd_pkg::gpr_bx; idx_next = opd_pkg::gpr_di; end
					3'h2: begin base_next = opd_pkg::gpr_bp; idx_next = opd_pkg::gpr_si; end
					3'h3: begin base_next = opd_pkg::gpr_bp; idx_next = opd_pkg::gpr_di; end
					3'h4: base_next = opd_pkg::gpr_si;
					3'h5: base_next = opd_pkg::gpr_di;
					3'h6: base_next = opd_pkg::gpr_bp;
					3'h7: base_next = opd_pkg::gpr_bx;
				endcase
				idx_v_next = (rm_f < 3'h4);
				if (base_next == opd_pkg::gpr_bp) begin
					seg_next = opd_pkg::seg_ss;
				end
				if (mod_f == `OPD_MOD_NODISP && rm_f == `OPD_RM16_DIRECT) begin
					base_v_next = 1'b0;
					base_next = opd_pkg::gpr_none;
					disp_next = opd_pkg::disp16;
					seg_next = opd_pkg::seg_ds;
				end else if (mod_f == `OPD_MOD_DISP8) begin
					disp_next = opd_pkg::disp8;
				end else if (mod_f == `OPD_MOD_DISPW) begin
					disp_next = opd_pkg::disp16;
				end
			end else begin
				// 32-bit interpretation with 32-bit components
				seg_next = opd_pkg::seg_ds;
				disp_next = (mod_f == `OPD_MOD_DISP8) ? opd_pkg::disp8 :
					(mod_f == `OPD_MOD_DISPW) ? opd_pkg::disp32 : opd_pkg::disp_none;
				if (rm_f == `OPD_RM_SIB) begin
					sib_next = 1'b1;
					scale_next = ss_f;
					idx_v_next = (idx_f != `OPD_IDX_NONE);
					idx_next = idx_v_next ? sib_idx_ext : opd_pkg::gpr_none;
					base_v_next = 1'b1;
					base_next = sib_base_ext;
					if (base_f == `OPD_BASE32_STACK) begin
						seg_next = opd_pkg::seg_ss;
					end else if (base_f == `OPD_BASE32_DIRECT) begin
						if (mod_f == `OPD_MOD_NODISP) begin
							base_v_next = 1'b0;
							base_next = opd_pkg::gpr_none;
							disp_next = opd_pkg::disp32;
						end else begin
							seg_next = opd_pkg::seg_ss;
						end
					end
				end else begin
					base_v_next = 1'b1;
					base_next = rm_ext;
					if (rm_f == `OPD_BASE32_DIRECT) begin
						if (mod_f == `OPD_MOD_NODISP) begin
							base_v_next = 1'b0;
							base_next = opd_pkg::gpr_none;
							disp_next = opd_pkg::disp32;
						end else begin
							seg_next = opd_pkg::seg_ss;
						end
					end
				end
			end
		end
	end

	// segment field decode
	opd_pkg::opd_seg_t seg2_next;
	opd_pkg::opd_seg_t seg3_next;
	logic seg3_rsvd;

	always_comb begin
		unique case (segment_select_2b_i)
			2'h0: seg2_next = opd_pkg::seg_es;
			2'h1: seg2_next = opd_pkg::seg_cs;
			2'h2: seg2_next = opd_pkg::seg_ss;
			2'h3: seg2_next = opd_pkg::seg_ds;
		endcase
	end

	assign seg3_rsvd = (segment_select_3b_i >= `OPD_SEG3_RSVD_MIN);

	always_comb begin
		unique case (segment_select_3b_i)
			3'h0: seg3_next = opd_pkg::seg_es;
			3'h1: seg3_next = opd_pkg::seg_cs;
			3'h2: seg3_next = opd_pkg::seg_ss;
			3'h3: seg3_next = opd_pkg::seg_ds;
			3'h4: seg3_next = opd_pkg::seg_fs;
			3'h5: seg3_next = opd_pkg::seg_gs;
			// reserved codes name no segment; invalid_opcode_o flags them instead
			default: seg3_next = opd_pkg::seg_none;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_valid_o <= `OPD_RST_BIT;
		end else begin
			out_valid_o <= req_valid_i;
		end
	end

	// results hold between requests
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op32_o <= `OPD_RST_BIT;
			addr32_o <= `OPD_RST_BIT;
			operand_size_o <= opd_pkg::size_8;
		end else if (req_valid_i) begin
			op32_o <= op32_next;
			addr32_o <= addr32_next;
			operand_size_o <= size_next;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_valid_o <= `OPD_RST_BIT;
			reg_sel_o <= opd_pkg::gpr_none;
			ext_valid_o <= `OPD_RST_BIT;
			opcode_extension_bits_o <= `OPD_RST_CODE3;
		end else if (req_valid_i) begin
			reg_valid_o <= has_modrm_i & ~opcode_ext_sel_i;
			reg_sel_o <= (has_modrm_i && !opcode_ext_sel_i) ? reg_map : opd_pkg::gpr_none;
			ext_valid_o <= has_modrm_i & opcode_ext_sel_i;
			opcode_extension_bits_o <= opcode_ext_sel_i ? reg_f : `OPD_RST_CODE3;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rm_is_reg_o <= `OPD_RST_BIT;
			rm_reg_o <= opd_pkg::gpr_none;
		end else if (req_valid_i) begin
			rm_is_reg_o <= has_modrm_i & ~fixed_stack_mode_i & (mod_f == `OPD_MOD_REG);
			rm_reg_o <= (has_modrm_i && !fixed_stack_mode_i && mod_f == `OPD_MOD_REG) ?
				rm_map : opd_pkg::gpr_none;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_valid_o <= `OPD_RST_BIT;
			sib_needed_o <= `OPD_RST_BIT;
			base_valid_o <= `OPD_RST_BIT;
			base_o <= opd_pkg::gpr_none;
			index_valid_o <= `OPD_RST_BIT;
			index_o <= opd_pkg::gpr_none;
			scale_o <= `OPD_RST_SCALE;
			disp_size_o <= opd_pkg::disp_none;
			ea_seg_o <= opd_pkg::seg_none;
			fixed_mode_o <= `OPD_RST_BIT;
		end else if (req_valid_i) begin
			mem_valid_o <= mem_next;
			sib_needed_o <= sib_next;
			base_valid_o <= base_v_next;
			base_o <= base_next;
			index_valid_o <= idx_v_next;
			index_o <= idx_next;
			scale_o <= scale_next;
			disp_size_o <= disp_next;
			ea_seg_o <= seg_next;
			fixed_mode_o <= fixed_stack_mode_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			segment_select_2b_o <= opd_pkg::seg_none;
			segment_select_3b_o <= opd_pkg::seg_none;
			seg3_valid_o <= `OPD_RST_BIT;
			invalid_opcode_o <= `OPD_RST_BIT;
		end else if (req_valid_i) begin
			segment_select_2b_o <= seg2_next;
			segment_select_3b_o <= seg3_used_i ? seg3_next : opd_pkg::seg_none;
			seg3_valid_o <= seg3_used_i & ~seg3_rsvd;
			invalid_opcode_o <= seg3_used_i & seg3_rsvd;
		end
	end

endmodule : opd_decoder

/* opd_decoder_assertions.sv */
`timescale 1ns/1ns
module opd_chk (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// request fields
	input wire logic req_valid_i,
	input wire logic has_modrm_i,
	input wire logic [7:0] modrm_i,
	input wire logic opcode_ext_sel_i,
	input wire logic fixed_stack_mode_i,
	input wire logic [1:0] segment_select_2b_i,
	input wire logic [2:0] segment_select_3b_i,
	input wire logic seg3_used_i,
	input wire logic cs_default_size_i,
	input wire logic real_or_v86_i,
	input wire logic opsize_prefix_i,
	input wire logic addrsize_prefix_i,
	// decode results
	input wire logic out_valid_o,
	input wire logic op32_o,
	input wire logic addr32_o,
	input wire logic reg_valid_o,
	input wire logic ext_valid_o,
	input wire logic [2:0] opcode_extension_bits_o,
	input wire logic rm_is_reg_o,
	input wire logic mem_valid_o,
	input wire logic sib_needed_o,
	input wire opd_pkg::opd_seg_t ea_seg_o,
	input wire logic fixed_mode_o,
	input wire opd_pkg::opd_seg_t segment_select_2b_o,
	input wire opd_pkg::opd_seg_t segment_select_3b_o,
	input wire logic seg3_valid_o,
	input wire logic invalid_opcode_o
);
	wire a32 = (cs_default_size_i & ~real_or_v86_i) ^ addrsize_prefix_i;
	wire o32 = (cs_default_size_i & ~real_or_v86_i) ^ opsize_prefix_i;
	wire mem_req = req_valid_i && has_modrm_i && !fixed_stack_mode_i;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_sib_req;
		mem_req && a32 && modrm_i[2:0] == 3'h4 && modrm_i[7:6] != 2'h3;
	endsequence
	sequence s_reg_req;
		mem_req && modrm_i[7:6] == 2'h3;
	endsequence
	sequence s_rsvd3;
		req_valid_i && seg3_used_i && segment_select_3b_i >= 3'h6;
	endsequence
	a_out_pulse: assert property (1'b1 |=> out_valid_o == $past(req_valid_i))
		else $error("result strobe not one cycle after request");
	a_hold_idle: assert property (!req_valid_i |=> $stable(ea_seg_o) && $stable(op32_o))
		else $error("results changed without a request");
	a_size_sel: assert property (req_valid_i |=> op32_o == $past(o32) && addr32_o == $past(a32))
		else $error("operand or address size wrong");
	a_sib_expect: assert property (s_sib_req |=> sib_needed_o && mem_valid_o)
		else $error("sib byte not expected");
	a_sib_only32: assert property (sib_needed_o |-> addr32_o)
		else $error("sib expected under 16-bit addressing");
	a_seg2_map: assert property (req_valid_i |=>
		3'(segment_select_2b_o) == {1'b0, $past(segment_select_2b_i)} + 3'h1)
		else $error("two-bit segment decode wrong");
	a_seg3_rsvd: assert property (s_rsvd3 |=> invalid_opcode_o && !seg3_valid_o
		&& segment_select_3b_o == opd_pkg::seg_none)
		else $error("reserved segment code not refused");
	a_seg3_legal: assert property (req_valid_i && seg3_used_i && segment_select_3b_i < 3'h6 |=>
		3'(segment_select_3b_o) == $past(segment_select_3b_i) + 3'h1 && seg3_valid_o)
		else $error("three-bit segment decode wrong");
	a_rm_reg_mode: assert property (s_reg_req |=> rm_is_reg_o && !mem_valid_o)
		else $error("mode 11 not a register operand");
	a_ext_field: assert property (req_valid_i && has_modrm_i && opcode_ext_sel_i |=> ext_valid_o
		&& !reg_valid_o && opcode_extension_bits_o == $past(modrm_i[5:3]))
		else $error("opcode extension not reported");
	a_fixed_stack: assert property (req_valid_i && fixed_stack_mode_i |=> fixed_mode_o
		&& ea_seg_o == opd_pkg::seg_ss && !rm_is_reg_o)
		else $error("stack mode not predetermined");
endmodule : opd_chk

bind opd_decoder opd_chk u_chk (.clk_sys_i, .rst_n_i, .req_valid_i, .has_modrm_i, .modrm_i,
	.opcode_ext_sel_i, .fixed_stack_mode_i, .segment_select_2b_i, .segment_select_3b_i,
	.seg3_used_i, .cs_default_size_i, .real_or_v86_i, .opsize_prefix_i, .addrsize_prefix_i,
	.out_valid_o, .op32_o, .addr32_o, .reg_valid_o, .ext_valid_o, .opcode_extension_bits_o,
	.rm_is_reg_o, .mem_valid_o, .sib_needed_o, .ea_seg_o, .fixed_mode_o, .segment_select_2b_o,
	.segment_select_3b_o, .seg3_valid_o, .invalid_opcode_o);

/* opd_agen_model.sv */
`timescale 1ns/1ns
// address side: takes each memory operand outside fixed stack mode, counts any that name no segment
module opd_agen_model (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// decode results
	input wire logic out_valid_o,
	input wire logic mem_valid_o,
	input wire logic fixed_mode_o,
	input wire opd_pkg::opd_seg_t ea_seg_o,
	// tallies
	output logic [7:0] mem_cnt_o,
	output logic [7:0] noseg_cnt_o
);
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_cnt_o <= 8'h00;
			noseg_cnt_o <= 8'h00;
		end else if (out_valid_o && mem_valid_o && !fixed_mode_o) begin
			mem_cnt_o <= mem_cnt_o + 8'h01;
			if (ea_seg_o == opd_pkg::seg_none) begin
				noseg_cnt_o <= noseg_cnt_o + 8'h01;
			end
		end
	end
endmodule : opd_agen_model

/* testbench.sv */
`timescale 1ns/1ns
module testbench;
	logic clk_sys_i = 1'b0, rst_n_i = 1'b0, req_valid_i = 1'b0, has_modrm_i = 1'b0;
	logic width_present_i = 1'b0, width_bit_i = 1'b0, opcode_ext_sel_i = 1'b0;
	logic fixed_stack_mode_i = 1'b0, seg3_used_i = 1'b0, cs_default_size_i = 1'b0;
	logic real_or_v86_i = 1'b0, opsize_prefix_i = 1'b0, addrsize_prefix_i = 1'b0;
	logic [7:0] modrm_i = 8'h00, sib_i = 8'h00, mem_cnt, noseg_cnt;
	logic [1:0] segment_select_2b_i = 2'h0, scale_o;
	logic [2:0] segment_select_3b_i = 3'h0, opcode_extension_bits_o;
	logic out_valid_o, op32_o, addr32_o, reg_valid_o, ext_valid_o, rm_is_reg_o, mem_valid_o;
	logic sib_needed_o, base_valid_o, index_valid_o, fixed_mode_o, seg3_valid_o, invalid_opcode_o;
	opd_pkg::opd_size_t operand_size_o;
	opd_pkg::opd_gpr_t reg_sel_o, rm_reg_o, base_o, index_o;
	opd_pkg::opd_disp_t disp_size_o;
	opd_pkg::opd_seg_t ea_seg_o, segment_select_2b_o, segment_select_3b_o;
	int bad_count = 0, checks = 0, cycles = 0, exp_mem = 0;

	opd_decoder #(.REG_CODE_W(3)) dut (.clk_sys_i, .rst_n_i, .req_valid_i, .has_modrm_i, .modrm_i,
		.sib_i, .width_present_i, .width_bit_i, .opcode_ext_sel_i, .fixed_stack_mode_i,
		.segment_select_2b_i, .segment_select_3b_i, .seg3_used_i, .cs_default_size_i,
		.real_or_v86_i, .opsize_prefix_i, .addrsize_prefix_i, .out_valid_o, .op32_o, .addr32_o,
		.operand_size_o, .reg_valid_o, .reg_sel_o, .ext_valid_o, .opcode_extension_bits_o,
		.rm_is_reg_o, .rm_reg_o, .mem_valid_o, .sib_needed_o, .base_valid_o, .base_o,
		.index_valid_o, .index_o, .scale_o, .disp_size_o, .ea_seg_o, .fixed_mode_o,
		.segment_select_2b_o, .segment_select_3b_o, .seg3_valid_o, .invalid_opcode_o);
	opd_agen_model agen (.clk_sys_i, .rst_n_i, .out_valid_o, .mem_valid_o, .fixed_mode_o,
		.ea_seg_o, .mem_cnt_o(mem_cnt), .noseg_cnt_o(noseg_cnt));

	initial forever #4 clk_sys_i = ~clk_sys_i;
	task print_verdict;
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	// a hang would otherwise never reach the verdict
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			print_verdict();
		end
	end
	task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	// request launched at the previous edge; results settle after this one
	task answer;
		@(posedge clk_sys_i);
		req_valid_i <= 1'b0;
		#1;
	endtask : answer
	task ctx(input logic cs, input logic ad, input logic fx, input logic ex);
		@(posedge clk_sys_i);
		cs_default_size_i <= cs;
		addrsize_prefix_i <= ad;
		fixed_stack_mode_i <= fx;
		opcode_ext_sel_i <= ex;
		has_modrm_i <= 1'b1;
		width_present_i <= 1'b1;
		width_bit_i <= 1'b1;
		seg3_used_i <= 1'b0;
	endtask : ctx
	task t_reg;
		logic [7:0] e;
		ctx(1'b0, 1'b0, 1'b0, 1'b0);
		for (int m = 0; m < 4; m++) for (int c = 0; c < 8; c++) begin
			@(posedge clk_sys_i);
			cs_default_size_i <= m[1];
			width_bit_i <= (m == 1 || m == 2);
			modrm_i <= {2'h3, 3'(c), 3'(c)};
			req_valid_i <= 1'b1;
			answer();
			e = (m == 3) ? 8'(1 + c) : 8'(1 + 8 * m + c);
			chk("reg_sel", reg_sel_o, e);
			chk("rm_reg", rm_reg_o, e);
			chk("op_size", operand_size_o, (m == 3) ? 8'h00 : 8'(m));
		end
	endtask : t_reg
	task t_seg;
		for (int c = 0; c < 8; c++) begin
			@(posedge clk_sys_i);
			segment_select_2b_i <= 2'(c);
			segment_select_3b_i <= 3'(c);
			seg3_used_i <= 1'b1;
			req_valid_i <= 1'b1;
			answer();
			chk("seg2", segment_select_2b_o, 8'(c % 4 + 1));
			chk("seg3", segment_select_3b_o, (c < 6) ? 8'(c + 1) : 8'h00);
			chk("invalid", invalid_opcode_o, 8'(c >= 6));
		end
		@(posedge clk_sys_i);
		segment_select_3b_i <= 3'h5;
		req_valid_i <= 1'b1;
		@(posedge clk_sys_i);
		segment_select_3b_i <= 3'h6;
		#1;
		chk("b2b_seg3", segment_select_3b_o, 8'h06);
		answer();
		chk("b2b_bad", invalid_opcode_o, 8'h01);
		@(posedge clk_sys_i);
		segment_select_3b_i <= 3'h1;
		@(posedge clk_sys_i);
		#1;
		chk("hold_seg3", seg3_valid_o, 8'h00);
		chk("hold_bad", invalid_opcode_o, 8'h01);
	endtask : t_seg
	task t_size;
		for (int k = 0; k < 16; k++) begin
			@(posedge clk_sys_i);
			{addrsize_prefix_i, opsize_prefix_i, real_or_v86_i, cs_default_size_i} <= 4'(k);
			width_present_i <= 1'b0;
			req_valid_i <= 1'b1;
			answer();
			chk("op32", op32_o, 8'((k % 2 == 1 && k[1] == 0) ^ k[2]));
			chk("addr32", addr32_o, 8'((k % 2 == 1 && k[1] == 0) ^ k[3]));
			chk("full_size", operand_size_o, 8'(1 + ((k % 2 == 1 && k[1] == 0) ^ k[2])));
		end
	endtask : t_size
	task t_mid;
		ctx(1'b0, 1'b0, 1'b0, 1'b1);
		@(posedge clk_sys_i);
		modrm_i <= 8'h2b;
		req_valid_i <= 1'b1;
		// mode 00 here also addresses memory, so the address side counts it
		exp_mem++;
		answer();
		chk("ext_bits", opcode_extension_bits_o, 8'h05);
		chk("ext_reg", reg_sel_o, 8'h00);
	endtask : t_mid
	task t_ea(input logic a32);
		byte unsigned bs[8] = '{12, 12, 14, 14, 15, 16, 14, 12};
		byte unsigned ix[8] = '{15, 16, 15, 16, 0, 0, 0, 0};
		int r;
		logic dr;
		logic sb;
		int xi;
		ctx(1'b0, a32, 1'b0, 1'b0);
		for (int md = 0; md < 3; md++) for (int q = 0; q < 15; q++) begin
			r = (q < 8) ? q : 4;
			if (a32 || q < 8) begin
				@(posedge clk_sys_i);
				modrm_i <= {2'(md), 3'h0, 3'(r)};
				sib_i <= {2'h2, 3'(q ^ 1), 3'(q)};
				req_valid_i <= 1'b1;
				exp_mem++;
				answer();
				if (!a32) begin
					dr = (md == 0 && r == 6);
					chk("base16", base_o, dr ? 8'h00 : bs[r]);
					chk("index16", index_o, ix[r]);
					chk("index_v16", index_valid_o, 8'(r < 4));
					chk("seg16", ea_seg_o, (r == 2 || r == 3 || (r == 6 && !dr)) ? 8'h03 : 8'h04);
					chk("disp16", disp_size_o, (md == 1) ? 8'h01 : (md == 2 || dr) ? 8'h02 : 8'h00);
				end else begin
					r = (q < 8) ? r : q - 8;
					dr = (md == 0 && r == 5);
					sb = (q == 4 || q >= 8);
					xi = (q ^ 1) % 8;
					chk("sib", sib_needed_o, 8'(sb));
					chk("index32", index_o, (sb && xi != 4) ? 8'(17 + xi) : 8'h00);
					chk("index_v32", index_valid_o, 8'(sb && xi != 4));
					chk("scale", scale_o, sb ? 8'h02 : 8'h00);
					chk("base32", base_o, dr ? 8'h00 : 8'(17 + r));
					chk("seg32", ea_seg_o, ((q >= 8 || q == 4) && r == 4) || (r == 5 && !dr)
						? 8'h03 : 8'h04);
					chk("disp32", disp_size_o, (md == 1) ? 8'h01 : (md == 2 || dr) ? 8'h03 : 8'h00);
				end
				chk("base_v", base_valid_o, 8'(!dr));
			end
		end
	endtask : t_ea
	task t_fixed;
		for (int k = 0; k < 2; k++) begin
			ctx(1'b0, k[0], 1'b1, 1'b0);
			@(posedge clk_sys_i);
			modrm_i <= 8'hc0;
			req_valid_i <= 1'b1;
			answer();
			chk("stack_base", base_o, k ? 8'd21 : 8'd13);
			chk("stack_disp", disp_size_o, 8'h00);
		end
	endtask : t_fixed

	initial begin
		repeat (16) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_reg();
		t_seg();
		t_size();
		t_mid();
		t_ea(1'b0);
		t_ea(1'b1);
		t_fixed();
		#1;
		chk("mem_count", mem_cnt, 8'(exp_mem));
		chk("no_segment", noseg_cnt, 8'h00);
		print_verdict();
	end
endmodule : testbench
